/* fcse_top.sv */
/*
 Command interpreter, internal operation sequencer and status reporting.
 Assumes bus pins arrive asynchronously; array and lock map share sys_clk.
*/
`timescale 1ns/100ps
module fcse_top #(
  parameter logic [15:0] MAKER_ID = 16'h1234, // Arbitrary value
  parameter logic [15:0] PART_ID = 16'h5678, // Arbitrary value
  parameter logic [23:0] ERASE_CYC = 24'(fcse_pkg::ERASE_CYC)
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic addr_valid_n,
  input wire logic burst_clk,
  input wire logic lock_guard,
  input wire logic vpp_ok,
  input wire logic [19:0] addr,
  input wire logic [15:0] dq_i,
  input wire logic block_locked,
  input wire logic [15:0] array_rdata,
  output logic [15:0] dq_o,
  output logic dq_oe,
  output logic arr_prog,
  output logic arr_erase,
  output logic [19:0] arr_addr,
  output logic [15:0] arr_data,
  output logic page_mode,
  output logic pseudo_standby
);
  // ==================================================
  // Pin synchronisers and edge history
  logic [42:0] s1_q, s2_q;
  logic [4:0] p_q;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s1_q <= '1;
      s2_q <= '1;
      p_q <= '1;
    end else begin
      s1_q <= {ce_n, oe_n, we_n, addr_valid_n, burst_clk, lock_guard, vpp_ok, addr, dq_i};
      s2_q <= s1_q;
      p_q <= s2_q[42:38];
    end
  end

  // Synchronised pin views
  logic ce_s, oe_s, we_s, adv_s, bclk_s, wp_s, vpp_s;
  logic [19:0] addr_s;
  logic [15:0] din_s;
  assign {ce_s, oe_s, we_s, adv_s, bclk_s, wp_s, vpp_s} = s2_q[42:36];
  assign addr_s = s2_q[35:16];
  assign din_s = s2_q[15:0];

  // ==================================================
  // Decode helpers
  function automatic logic fcse_is_prog(input logic [7:0] d);
    return (d == fcse_pkg::CMD_PROG_SETUP) || (d == fcse_pkg::CMD_PROG_ALT);
  endfunction
  function automatic logic [4:0] fcse_blk(input logic [19:0] a);
    return a[19:fcse_pkg::BLK_LSB];
  endfunction

  // ==================================================
  // State registers
  fcse_pkg::fcse_rmode_e rmode_q, rmode_d;
  fcse_pkg::fcse_cmd_e cmd_q, cmd_d;
  logic [19:0] addr_q, pg_addr_q;
  logic [15:0] pg_data_q, rcfg_q;
  logic [7:0] err_q, snap_q, lat_q;
  logic [4:0] er_blk_q;
  logic [23:0] pg_cnt_q, er_cnt_q;
  logic pg_act_q, pg_sus_q, er_act_q, er_sus_q;
  logic sus_pend_q, sus_pg_q, snap_lock_q;

  // Write end on strobe rise, clock pin not involved
  logic wr_end, adv_rise;
  logic [19:0] cur_addr;
  logic [7:0] wd;
  assign wr_end = oe_s & ((we_s & ~p_q[2] & ~p_q[4]) | (ce_s & ~p_q[4] & ~p_q[2]));
  assign adv_rise = adv_s & ~p_q[1];
  assign cur_addr = adv_s ? addr_q : addr_s;
  assign wd = din_s[7:0];

  // Operation activity
  logic pg_busy, er_busy, busy, in_esus;
  assign pg_busy = pg_act_q & ~pg_sus_q;
  assign er_busy = er_act_q & ~er_sus_q;
  assign busy = pg_busy | er_busy;
  assign in_esus = er_act_q & er_sus_q;

  // First-cycle command decode; no supply check here
  logic cmd_ev, ok_esus, acc;
  assign cmd_ev = wr_end & (cmd_q == fcse_pkg::CS_READY);
  assign ok_esus = (wd == fcse_pkg::CMD_READ_ARRAY) | fcse_is_prog(wd)
    | (wd == fcse_pkg::CMD_SUSPEND) | (wd == fcse_pkg::CMD_READ_STATUS)
    | (wd == fcse_pkg::CMD_CONFIRM);
  assign acc = cmd_ev & (~in_esus | ok_esus)
    & ~((wd == fcse_pkg::CMD_READ_ARRAY) & busy);

  // Accepted commands
  logic a_ff, a_id, a_st, a_clr, a_erase, a_prog, a_susp, a_res, a_cfg;
  assign a_ff = acc & (wd == fcse_pkg::CMD_READ_ARRAY);
  assign a_id = acc & (wd == fcse_pkg::CMD_READ_ID);
  assign a_st = acc & (wd == fcse_pkg::CMD_READ_STATUS);
  assign a_clr = acc & (wd == fcse_pkg::CMD_CLEAR_STATUS);
  assign a_erase = acc & (wd == fcse_pkg::CMD_ERASE_SETUP) & ~er_act_q & ~pg_act_q;
  assign a_prog = acc & fcse_is_prog(wd) & ~pg_act_q & ~er_busy;
  assign a_susp = acc & (wd == fcse_pkg::CMD_SUSPEND) & busy & ~sus_pend_q;
  assign a_res = acc & (wd == fcse_pkg::CMD_CONFIRM) & (pg_sus_q | er_sus_q);
  assign a_cfg = acc & (wd == fcse_pkg::CMD_CFG_SETUP);

  // Second-cycle decode
  logic p2, e2, g2, e_ok, g_ok, lock_bad, pg_bad, pg_start, er_start, bad_seq;
  assign p2 = wr_end & (cmd_q == fcse_pkg::CS_PROG);
  assign e2 = wr_end & (cmd_q == fcse_pkg::CS_ERASE);
  assign g2 = wr_end & (cmd_q == fcse_pkg::CS_CFG);
  assign e_ok = e2 & (wd == fcse_pkg::CMD_CONFIRM);
  assign g_ok = g2 & (wd == fcse_pkg::CMD_CFG_CONFIRM);
  assign lock_bad = block_locked & ~wp_s;
  assign pg_bad = p2 & in_esus & (fcse_blk(cur_addr) == er_blk_q);
  assign pg_start = p2 & ~lock_bad & ~pg_bad;
  assign er_start = e_ok & ~lock_bad;
  assign bad_seq = (e2 & ~e_ok) | (g2 & ~g_ok) | pg_bad;

  // Progress, supply test and completion
  logic pg_run, pg_vlow, pg_done, er_run, er_vlow, er_done, lat_done;
  assign pg_run = pg_busy & vpp_s;
  assign pg_vlow = pg_busy & ~vpp_s;
  assign pg_done = pg_run & (pg_cnt_q == fcse_pkg::PROG_LAST);
  assign er_run = er_busy & ~pg_act_q & vpp_s;
  assign er_vlow = er_busy & ~pg_act_q & ~vpp_s;
  assign er_done = er_run & (er_cnt_q == ERASE_CYC - 24'h000001);
  assign lat_done = sus_pend_q & (lat_q == fcse_pkg::SUSP_LAST);

  // Error flags: set wins over clear
  logic [7:0] set_v, err_d;
  assign set_v[fcse_pkg::SB_EFAIL] = bad_seq | (e_ok & lock_bad) | er_vlow;
  assign set_v[fcse_pkg::SB_PFAIL] = bad_seq | (p2 & lock_bad) | pg_vlow;
  assign set_v[fcse_pkg::SB_VLOW] = er_vlow | pg_vlow;
  assign set_v[fcse_pkg::SB_LOCK] = lock_bad & (p2 | e_ok);
  assign {set_v[7:6], set_v[2], set_v[0]} = 4'h0;
  assign err_d = (a_clr ? (err_q & ~fcse_pkg::ERR_MASK) : err_q) | set_v;

  // Read mode selection
  always_comb begin
    rmode_d = rmode_q;
    if (a_ff | a_clr | g_ok) begin
      rmode_d = fcse_pkg::RM_ARRAY;
    end else if (a_id) begin
      rmode_d = fcse_pkg::RM_ID;
    end else if (a_st | a_erase | a_prog | a_susp | a_res | p2 | e2 | g2) begin
      rmode_d = fcse_pkg::RM_STATUS;
    end
  end

  // Command sequence state
  always_comb begin
    cmd_d = cmd_q;
    unique case (cmd_q)
      fcse_pkg::CS_READY: begin
        if (a_erase) begin
          cmd_d = fcse_pkg::CS_ERASE;
        end else if (a_prog) begin
          cmd_d = fcse_pkg::CS_PROG;
        end else if (a_cfg) begin
          cmd_d = fcse_pkg::CS_CFG;
        end
      end
      fcse_pkg::CS_PROG, fcse_pkg::CS_ERASE, fcse_pkg::CS_CFG: begin
        if (wr_end) begin
          cmd_d = fcse_pkg::CS_READY;
        end
      end
    endcase
  end

  // Command interface registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rmode_q <= fcse_pkg::RM_ARRAY;
      cmd_q <= fcse_pkg::CS_READY;
      rcfg_q <= fcse_pkg::RCFG_RST;
      err_q <= 8'h00;
      addr_q <= 20'h00000;
    end else begin
      rmode_q <= rmode_d;
      cmd_q <= cmd_d;
      rcfg_q <= g_ok ? cur_addr[15:0] : rcfg_q;
      err_q <= err_d;
      addr_q <= adv_rise ? addr_s : addr_q;
    end
  end

  // Program sequencer
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pg_act_q <= 1'b0;
      pg_sus_q <= 1'b0;
      pg_cnt_q <= 24'h000000;
      pg_addr_q <= 20'h00000;
      pg_data_q <= 16'h0000;
    end else begin
      pg_act_q <= pg_start | (pg_act_q & ~pg_done & ~pg_vlow);
      if (lat_done & sus_pg_q & pg_act_q) begin
        pg_sus_q <= 1'b1;
      end else if (a_res & pg_sus_q) begin
        pg_sus_q <= 1'b0;
      end
      pg_cnt_q <= pg_start ? 24'h000000 : (pg_run ? pg_cnt_q + 24'h000001 : pg_cnt_q);
      pg_addr_q <= pg_start ? cur_addr : pg_addr_q;
      pg_data_q <= pg_start ? din_s : pg_data_q;
    end
  end

  // Erase sequencer and suspend latency
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      er_act_q <= 1'b0;
      er_sus_q <= 1'b0;
      er_cnt_q <= 24'h000000;
      er_blk_q <= 5'h00;
      sus_pend_q <= 1'b0;
      sus_pg_q <= 1'b0;
      lat_q <= 8'h00;
    end else begin
      er_act_q <= er_start | (er_act_q & ~er_done & ~er_vlow);
      if (lat_done & ~sus_pg_q & er_act_q) begin
        er_sus_q <= 1'b1;
      end else if (a_res & ~pg_sus_q) begin
        er_sus_q <= 1'b0;
      end
      er_cnt_q <= er_start ? 24'h000000 : (er_run ? er_cnt_q + 24'h000001 : er_cnt_q);
      er_blk_q <= er_start ? fcse_blk(cur_addr) : er_blk_q;
      sus_pend_q <= a_susp | (sus_pend_q & ~lat_done & busy);
      sus_pg_q <= a_susp ? pg_busy : sus_pg_q;
      lat_q <= a_susp ? 8'h00 : lat_q + 8'h01;
    end
  end

  // ==================================================
  // Status snapshot and read data
  logic snap_ev, rd_act;
  logic [7:0] stat_now, snap_d;
  logic [15:0] id_word, rd_word;
  assign stat_now = err_q | ({7'h00, ~busy} << fcse_pkg::SB_READY)
    | ({7'h00, er_sus_q} << fcse_pkg::SB_ESUSP)
    | ({7'h00, pg_sus_q} << fcse_pkg::SB_PSUSP);
  assign snap_ev = ~snap_lock_q & (adv_rise
    | (~rcfg_q[fcse_pkg::RCFG_MODE_BIT] & bclk_s & ~p_q[0] & ~adv_s)
    | (~oe_s & p_q[3]) | (~ce_s & p_q[4]));
  assign snap_d = snap_ev ? stat_now : snap_q;
  assign rd_act = ~ce_s & ~oe_s;
  assign id_word = (cur_addr == fcse_pkg::ID_ADDR_MAKER) ? MAKER_ID
    : (cur_addr == fcse_pkg::ID_ADDR_PART) ? PART_ID
    : (cur_addr == fcse_pkg::ID_ADDR_CFG) ? rcfg_q : 16'h0000;
  assign rd_word = (rmode_q == fcse_pkg::RM_ARRAY) ? array_rdata
    : (rmode_q == fcse_pkg::RM_ID) ? id_word : {8'h00, snap_d};

  // Snapshot register, held until the read ends
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      snap_q <= fcse_pkg::STATUS_RST;
      snap_lock_q <= 1'b0;
    end else begin
      snap_q <= snap_d;
      snap_lock_q <= snap_ev | (snap_lock_q & ~(oe_s & ~p_q[3]) & ~(ce_s & ~p_q[4]));
    end
  end

  // Registered outputs
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dq_o <= 16'h0000;
      dq_oe <= 1'b0;
      arr_prog <= 1'b0;
      arr_erase <= 1'b0;
      arr_addr <= 20'h00000;
      arr_data <= 16'h0000;
      page_mode <= 1'b1;
      pseudo_standby <= 1'b0;
    end else begin
      dq_o <= rd_word;
      dq_oe <= rd_act & we_s;
      arr_prog <= pg_done;
      arr_erase <= er_done;
      arr_addr <= pg_done ? pg_addr_q : (er_done ? {er_blk_q, 15'h0000} : arr_addr);
      arr_data <= pg_done ? pg_data_q : (er_done ? 16'hFFFF : arr_data);
      page_mode <= rcfg_q[fcse_pkg::RCFG_MODE_BIT];
      pseudo_standby <= ce_s & in_esus;
    end
  end

  // ==================================================
  // Checks
  localparam int SUSP_CHK = 24;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  chk_reset_state: assert property (disable iff (1'b0) rst |=>
    rmode_q == fcse_pkg::RM_ARRAY && stat_now == fcse_pkg::STATUS_RST && !er_act_q)
    else $error("reset state wrong");
  chk_mode_holds: assert property (!wr_end |=> rmode_q == $past(rmode_q))
    else $error("read mode changed without a write");
  chk_ff_ignored: assert property (cmd_ev && wd == fcse_pkg::CMD_READ_ARRAY && busy
    |=> rmode_q == $past(rmode_q)) else $error("read array taken while busy");
  chk_id_maker: assert property (rmode_q == fcse_pkg::RM_ID &&
    cur_addr == fcse_pkg::ID_ADDR_MAKER |=> dq_o == MAKER_ID) else $error("bad maker code");
  chk_flag_hold: assert property ($fell(err_q[fcse_pkg::SB_EFAIL]) |-> $past(a_clr))
    else $error("error flag dropped without clear");
  chk_clear_mode: assert property (a_clr |=> rmode_q == fcse_pkg::RM_ARRAY)
    else $error("clear did not return to array");
  chk_op_status: assert property (pg_start || er_start |=>
    rmode_q == fcse_pkg::RM_STATUS && !stat_now[fcse_pkg::SB_READY]) else $error("no status");
  chk_bad_confirm: assert property (e2 && !e_ok |=>
    err_q[fcse_pkg::SB_EFAIL] && err_q[fcse_pkg::SB_PFAIL]) else $error("bad sequence");
  chk_vpp_abort: assert property (pg_busy && !vpp_s |=>
    !pg_act_q && err_q[fcse_pkg::SB_VLOW]) else $error("low supply not aborted");
  chk_lock_abort: assert property (p2 && lock_bad |=>
    !pg_act_q && err_q[fcse_pkg::SB_LOCK]) else $error("locked program ran");
  chk_esus_hold: assert property ($fell(er_sus_q) |-> $past(a_res))
    else $error("erase suspend dropped");
  chk_psus_hold: assert property ($fell(pg_sus_q) |-> $past(a_res))
    else $error("program suspend dropped");
  chk_susp_latency: assert property (a_susp |-> ##[1:SUSP_CHK]
    (stat_now[fcse_pkg::SB_READY])) else $error("suspend too slow");
  chk_erase_waits: assert property (er_act_q && pg_act_q |=> $stable(er_cnt_q))
    else $error("erase ran during program");
  chk_esus_filter: assert property (cmd_ev && in_esus && wd == fcse_pkg::CMD_READ_ID
    |=> rmode_q == $past(rmode_q)) else $error("command taken in erase suspend");
endmodule // fcse_top

/* fcse_pkg.sv */
/*
 Constants, codes and state types of the flash command and status engine.
 Assumes a 200 MHz system clock; pin timing is handled by the top module.
*/
package fcse_pkg;
  // ==================================================
  // Command codes
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_READ_ID = 8'h90;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CMD_PROG_SETUP = 8'h40;
  localparam logic [7:0] CMD_PROG_ALT = 8'h10;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_CFG_SETUP = 8'h60;
  localparam logic [7:0] CMD_CFG_CONFIRM = 8'h03;
  // ==================================================
  // Identifier addresses and block field
  localparam logic [19:0] ID_ADDR_MAKER = 20'h00000;
  localparam logic [19:0] ID_ADDR_PART = 20'h00001;
  localparam logic [19:0] ID_ADDR_CFG = 20'h00005;
  localparam int BLK_LSB = 15;
  // ==================================================
  // Status bit positions and reset values
  localparam int SB_READY = 7;
  localparam int SB_ESUSP = 6;
  localparam int SB_EFAIL = 5;
  localparam int SB_PFAIL = 4;
  localparam int SB_VLOW = 3;
  localparam int SB_PSUSP = 2;
  localparam int SB_LOCK = 1;
  localparam logic [7:0] ERR_MASK = 8'h3A;
  localparam logic [7:0] STATUS_RST = 8'h80;
  localparam logic [15:0] RCFG_RST = 16'h8000;
  localparam int RCFG_MODE_BIT = 15;
  // ==================================================
  // Internal operation timing
  localparam int CLK_MHZ = 200;
  localparam int PROG_TIME_NS = 10000;
  localparam int ERASE_TIME_NS = 100000;
  localparam int SUSP_LAT_NS = 100;
  localparam int PROG_CYC = PROG_TIME_NS * CLK_MHZ / 1000;
  localparam int ERASE_CYC = ERASE_TIME_NS * CLK_MHZ / 1000;
  localparam int SUSP_LAT_CYC = SUSP_LAT_NS * CLK_MHZ / 1000;
  localparam logic [23:0] PROG_LAST = 24'(PROG_CYC - 1);
  localparam logic [7:0] SUSP_LAST = 8'(SUSP_LAT_CYC - 1);
  // ==================================================
  // State types
  typedef enum logic [1:0] {RM_ARRAY, RM_ID, RM_STATUS} fcse_rmode_e;
  typedef enum logic [1:0] {CS_READY, CS_PROG, CS_ERASE, CS_CFG} fcse_cmd_e;
endpackage

/* fcse_host.sv */
/*
 Host processor model that drives the flash bus pins.
 Assumes one caller at a time, entering just after a rising edge.
*/
`timescale 1ns/100ps
module fcse_host (
  input wire logic sys_clk,
  input wire logic [15:0] dq_o,
  input wire logic dq_oe,
  output logic ce_n,
  output logic oe_n,
  output logic we_n,
  output logic addr_valid_n,
  output logic burst_clk,
  output logic [19:0] addr,
  output logic [15:0] dq_i
);
  // ==================================================
  // Idle pin levels; bus clock stands still in page mode
  initial begin
    {ce_n, oe_n, we_n, addr_valid_n} = 4'hF;
    burst_clk = 1'b0;
    addr = 20'h00000;
    dq_i = 16'hA5A5;
  end

  // Steps n edges, then lands just after the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // ==================================================
  // One bus write; erase and program are two calls
  task automatic wr(input logic [19:0] a, input logic [15:0] d);
    addr = a;
    dq_i = d;
    ce_n = 1'b0;
    addr_valid_n = 1'b0;
    cyc(4);
    addr_valid_n = 1'b1;
    we_n = 1'b0;
    cyc(4);
    we_n = 1'b1;
    cyc(4);
    ce_n = 1'b1;
    dq_i = ~d; // Released lines do not keep the old value
    addr = ~a;
    cyc(4);
  endtask

  // One single read; undriven data comes back as Z
  task automatic rd(input logic [19:0] a, output logic [15:0] d);
    addr = a;
    ce_n = 1'b0;
    addr_valid_n = 1'b0;
    cyc(3);
    addr_valid_n = 1'b1;
    oe_n = 1'b0;
    cyc(8);
    d = dq_oe ? dq_o : 16'hZZZZ;
    oe_n = 1'b1;
    ce_n = 1'b1;
    addr = ~a;
    cyc(4);
  endtask
endmodule // fcse_host

/* fcse_tb_top.sv */
/*
 Self-checking bench: reset, identifier, program, errors, erase and suspend.
 Assumes fcse_top and the host model; erase time shortened to 200 cycles.
*/
`timescale 1ns/100ps
module fcse_tb_top;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic lock_guard = 1'b1;
  logic vpp_ok = 1'b1;
  logic block_locked = 1'b0;
  logic [15:0] array_rdata = 16'h0000;
  logic ce_n, oe_n, we_n, addr_valid_n, burst_clk, dq_oe;
  logic arr_prog, arr_erase, page_mode, pseudo_standby;
  logic [19:0] addr, arr_addr;
  logic [15:0] dq_i, dq_o, arr_data, w, lfsr_q;
  logic [19:0] a;
  int bad_count = 0;
  int num_checks = 0;
  logic [19:0] id_addr [3] = '{20'h00000, 20'h00001, 20'h00005};
  logic [15:0] id_exp [3] = '{16'h1234, 16'h5678, 16'h8000};
  logic [15:0] err_exp [3] = '{16'h0098, 16'h0092, 16'h00B0};

  // ==================================================
  // Clock and instances
  always #2.5 sys_clk = ~sys_clk;

  fcse_top #(.ERASE_CYC(24'h0000C8)) fcse_top_inst (
    .sys_clk(sys_clk), .rst(rst), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
    .addr_valid_n(addr_valid_n), .burst_clk(burst_clk), .lock_guard(lock_guard),
    .vpp_ok(vpp_ok), .addr(addr), .dq_i(dq_i), .block_locked(block_locked),
    .array_rdata(array_rdata), .dq_o(dq_o), .dq_oe(dq_oe), .arr_prog(arr_prog),
    .arr_erase(arr_erase), .arr_addr(arr_addr), .arr_data(arr_data),
    .page_mode(page_mode), .pseudo_standby(pseudo_standby));

  fcse_host fcse_host_inst (
    .sys_clk(sys_clk), .dq_o(dq_o), .dq_oe(dq_oe), .ce_n(ce_n), .oe_n(oe_n),
    .we_n(we_n), .addr_valid_n(addr_valid_n), .burst_clk(burst_clk),
    .addr(addr), .dq_i(dq_i));

  // ==================================================
  // Helpers: random source, compare, status read, finish wait
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic chk(input logic [19:0] got, input logic [19:0] exp, input logic [19:0] m);
    num_checks++;
    if ((got & m) !== (exp & m)) begin
      bad_count++;
      $display("BAD %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // Status poll; reserved bit 0 is masked in the compare here
  task automatic st(input logic [15:0] e, input logic [15:0] m);
    fcse_host_inst.rd(20'h00000, w);
    chk({4'h0, w}, {4'h0, e}, {4'h0, m & 16'hFFFE});
  endtask

  task automatic wait_done(input bit er, input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      @(posedge sys_clk);
      #1;
      if ((er ? arr_erase : arr_prog) === 1'b1) break;
    end
    chk(20'(i < lim), 20'h00001, 20'h00001);
  endtask

  // Array read returns the word currently on the array port
  task automatic arr_rd;
    lfsr_q = lfsr_next(lfsr_q);
    array_rdata = lfsr_q;
    fcse_host_inst.rd({4'h1, lfsr_q}, w);
    chk({4'h0, w}, {4'h0, lfsr_q}, 20'h0FFFF);
  endtask

  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ==================================================
  // Watchdog
  initial begin
    #400000;
    bad_count++;
    $display("BAD %0t: timeout", $time);
    wrap_up();
  end

  // ==================================================
  // Main sequence
  initial begin
    lfsr_q = 16'h5701;
    repeat (4) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    fcse_host_inst.cyc(2);
    chk({19'h0, page_mode}, 20'h00001, 20'h00001);
    arr_rd();
    fcse_host_inst.wr(20'h00000, 16'h0070);
    st(16'h0080, 16'h00FF);
    fcse_host_inst.wr(20'h00000, 16'h0090);
    for (int i = 0; i < 3; i++) begin
      fcse_host_inst.rd(id_addr[i], w);
      chk({4'h0, w}, {4'h0, id_exp[i]}, 20'h0FFFF);
    end
    fcse_host_inst.wr(20'h00000, 16'h00FF);
    arr_rd();
    // Program with both setup codes; read array refused while busy
    for (int k = 0; k < 2; k++) begin
      lfsr_q = lfsr_next(lfsr_q);
      a = {4'h2, lfsr_q};
      fcse_host_inst.wr(20'h00000, k ? 16'h0010 : 16'h0040);
      fcse_host_inst.wr(a, ~lfsr_q);
      st(16'h0000, 16'h0080);
      array_rdata = 16'h0080; // Array word that would expose a taken read array
      fcse_host_inst.wr(20'h00000, 16'h00FF);
      st(16'h0000, 16'h0080);
      wait_done(1'b0, 2100);
      chk(arr_addr, a, 20'hFFFFF);
      chk({4'h0, arr_data}, {4'h0, ~lfsr_q}, 20'h0FFFF);
      st(16'h0080, 16'h0080);
    end
    // Supply low, locked block, bad erase confirm
    for (int c = 0; c < 3; c++) begin
      vpp_ok = (c != 0);
      block_locked = (c == 1);
      lock_guard = (c != 1);
      fcse_host_inst.wr(20'h00000, c == 2 ? 16'h0020 : 16'h0040);
      fcse_host_inst.wr(20'h08000, c == 2 ? 16'h00FF : 16'h1357);
      fcse_host_inst.cyc(30);
      st(err_exp[c], 16'h00FF);
      fcse_host_inst.wr(20'h00000, 16'h0070);
      st(err_exp[c], 16'h00FF);
      fcse_host_inst.wr(20'h00000, 16'h0050);
      arr_rd();
      vpp_ok = 1'b1;
      block_locked = 1'b0;
      lock_guard = 1'b1;
      fcse_host_inst.wr(20'h00000, 16'h0070);
      st(16'h0080, 16'h00FF);
    end
    // Erase with suspend, standby and read ID refused while suspended
    fcse_host_inst.wr(20'h00000, 16'h0020);
    fcse_host_inst.wr({5'h03, 15'h1234}, 16'h00D0);
    fcse_host_inst.wr(20'h00000, 16'h00B0);
    fcse_host_inst.cyc(30);
    st(16'h00C0, 16'h00FF);
    chk({19'h0, pseudo_standby}, 20'h00001, 20'h00001);
    fcse_host_inst.wr(20'h00000, 16'h0090);
    st(16'h00C0, 16'h00FF);
    // Program another block, then resume the erase while it runs
    fcse_host_inst.wr(20'h00000, 16'h0040);
    fcse_host_inst.wr(20'h20006, 16'h5AA5);
    fcse_host_inst.wr(20'h00000, 16'h00D0);
    st(16'h0000, 16'h00C0);
    wait_done(1'b0, 2100);
    chk(arr_addr, 20'h20006, 20'hFFFFF);
    wait_done(1'b1, 400);
    chk(arr_addr, {5'h03, 15'h0000}, 20'hFFFFF);
    chk({4'h0, arr_data}, 20'h0FFFF, 20'h0FFFF);
    // Program suspend and resume
    fcse_host_inst.wr(20'h00000, 16'h0040);
    fcse_host_inst.wr(20'h10002, 16'h2468);
    fcse_host_inst.wr(20'h00000, 16'h00B0);
    fcse_host_inst.cyc(30);
    st(16'h0084, 16'h00FF);
    fcse_host_inst.wr(20'h00000, 16'h00D0);
    st(16'h0000, 16'h0084);
    wait_done(1'b0, 2100);
    st(16'h0080, 16'h00FF);
    wrap_up();
  end
endmodule // fcse_tb_top
